/* lga_defs.vh */
`ifndef LGA_DEFS_VH
`define LGA_DEFS_VH
// host i/o map
`define LGA_HIO_LEGACY 16'h0092
`define LGA_HIO_KBD_DATA 16'h0060
`define LGA_HIO_KBD_CMD 16'h0064
// ec map
`define LGA_EC_A20_CTL 12'h100
`define LGA_EC_A20_SET 12'h104
`define LGA_EC_A20_CLR 12'h108
`define LGA_EC_OVR_EN 12'h10C
`define LGA_EC_LEGACY_EN 12'h110
`define LGA_EC_BAR_VALID 12'h114
`define LGA_EC_SLEEP_EN 12'h118
`define LGA_EC_ACTIVATE 12'h330
// config index
`define LGA_CFG_ACTIVATE 8'h30
// fields
`define LGA_BIT_ALT_RESET_PULSE_N 0
`define LGA_BIT_ALT_GATE 1
`define LGA_BIT_DATA_A20 1
// reset values
`define LGA_LEGACY_RST 8'h00
`define LGA_ACTIVATE_RST 1'b0
// commands
`define LGA_CMD_GATE 8'hD1
`define LGA_CMD_NOP 8'hFF
`define LGA_CMD_PULSE 8'hFE
// timing: 1 mhz tick from 250 mhz clock, pulse width in microseconds
`define LGA_CLK_MHZ 250
`define LGA_TICK_MHZ 1
`define LGA_TICK_DIV (`LGA_CLK_MHZ / `LGA_TICK_MHZ)
`define LGA_PULSE_US 8'd14
`endif

/* lga_host_model.sv */
module lga_host_model (
    input wire clock,
    input wire [7:0] host_data_bus,
    input wire host_data_oe,
    output logic host_wr,
    output logic host_rd,
    output logic [15:0] host_addr,
    output logic [7:0] host_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        host_wr = 0;
        host_rd = 0;
        host_addr = 16'hFFFF;
        host_wdata = 8'hA5;
    end
    // one-cycle i/o cycle; bus shows inverted values once released
    task io(input logic wr, input logic [15:0] a, input logic [7:0] v, output logic oe, output logic [7:0] d);
        @(negedge clock);
        host_wr = wr;
        host_rd = !wr;
        host_addr = a;
        host_wdata = v;
        #1 oe = host_data_oe;
        @(negedge clock);
        d = host_data_bus;
        host_wr = 0;
        host_rd = 0;
        host_addr = ~a;
        host_wdata = ~v;
    endtask
endmodule // lga_host_model

/* lga_pulse.v */
`include "lga_defs.vh"
module lga_pulse (
    input wire clock,
    input wire sys_rst,
    input wire ctl_bit,
    input wire tick,
    output reg pulse_n
);
    reg prev_q;
    reg [7:0] cnt_q;
    wire rise = ctl_bit & ~prev_q;
    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prev_q <= 1'b0;
            cnt_q <= 8'h00;
            pulse_n <= 1'b1;
        end
        else
        begin
            prev_q <= ctl_bit;
            // a rising bit while a pulse runs is swallowed [RQ16]
            if (rise && pulse_n)
            begin
                pulse_n <= 1'b0; // [RQ14]
                cnt_q <= `LGA_PULSE_US;
            end
            else if (!pulse_n && tick) // [RQ20]
            begin
                if (cnt_q == 8'h01)
                    pulse_n <= 1'b1;
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule // lga_pulse

/* lga_tick.v */
`include "lga_defs.vh"
module lga_tick (
    input wire clock,
    input wire sys_rst,
    input wire run,
    output reg tick
);
    localparam integer DIV_LAST_FULL = `LGA_TICK_DIV - 1;
    localparam [7:0] DIV_LAST = DIV_LAST_FULL[7:0];
    reg [7:0] cnt_q;
    // 1 mhz time base, counter cleared and tick held low while gated off
    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_q <= 8'h00;
            tick <= 1'b0;
        end
        else if (!run)
        begin
            cnt_q <= 8'h00;
            tick <= 1'b0;
        end
        else
        begin
            tick <= (cnt_q == DIV_LAST);
            cnt_q <= (cnt_q == DIV_LAST) ? 8'h00 : cnt_q + 8'h01;
        end
    end
endmodule // lga_tick

/* lga_top.v */
// How it works
// [RQ1] legacy register decoded at host 92h
// [RQ2] legacy register clears on main reset
// [RQ3] disabled port ignores writes, floats reads
// [RQ4] own base register, only valid writable
// [RQ5] override selects firmware a20 bit
// [RQ6] ec 100h reads actual gate output
// [RQ7] d1 then data copies bit 1
// [RQ8] gate transaction raises no firmware flags
// [RQ9] ff fe d1 suppress buffer write
// [RQ10] extra data byte sets buffer full, idle
// [RQ11] repeated d1 rearms the detector
// [RQ12] set/clear registers drive latch on write
// [RQ13] firmware rereads gate after direct writes
// [RQ14] alt reset pulse nanded with keyboard
// [RQ15] control bit cleared before new pulse
// [RQ16] no pulse if retoggled mid pulse
// [RQ17] tick gated by sleep or inactive
// [RQ18] activate at cfg 30h, ec 330h
// [RQ19] activate bit 0 defaults zero
// [RQ20] 1 mhz tick times reset pulse
// [RQ21] gate driven on dedicated pin
// [RQ22] legacy bit 1 ors with latch
`include "lga_defs.vh"
module lga_top (
    input wire clock,
    input wire sys_rst,
    input wire host_wr,
    input wire host_rd,
    input wire [15:0] host_addr,
    input wire [7:0] host_wdata,
    output reg [7:0] host_data_bus,
    output wire host_data_oe,
    input wire cfg_wr,
    input wire [7:0] cfg_index,
    input wire [7:0] cfg_wdata,
    output reg [7:0] cfg_rdata,
    input wire ec_wr,
    input wire ec_rd,
    input wire [11:0] ec_addr,
    input wire [7:0] ec_wdata,
    output reg [7:0] ec_rdata,
    input wire kbd_reset_pulse_n,
    output wire kbd_wr_strobe,
    output reg input_buffer_full,
    output wire kbd_obf_irq_flag,
    input wire input_buffer_clear,
    output wire a20_gate_out,
    output reg gate_pin_out,
    output reg cpu_reset_out
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ARMED = 2'b10;

    function is_addr;
        input [11:0] a;
        input [11:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [7:0] legacy_fast_reset_gate_q;
    reg firmware_a20_control_q;
    reg sw_a20_override_en_q;
    reg legacy_en_q;
    reg bar_valid_q;
    reg sleep_en_q;
    reg interface_activate_q;
    reg host_latch_q;
    reg [1:0] state_q;
    wire tick;
    wire alt_reset_pulse_n;

    wire hit_legacy = (host_addr == `LGA_HIO_LEGACY) && legacy_en_q; // [RQ1] [RQ3]
    wire hit_cmd = (host_addr == `LGA_HIO_KBD_CMD);
    wire hit_data = (host_addr == `LGA_HIO_KBD_DATA);
    wire cmd_gate = hit_cmd && (host_wdata == `LGA_CMD_GATE);
    wire cmd_quiet = hit_cmd && ((host_wdata == `LGA_CMD_GATE) || (host_wdata == `LGA_CMD_NOP)
                     || (host_wdata == `LGA_CMD_PULSE));
    wire data_gate = hit_data && (state_q == ST_ARMED);
    wire alt_reset_pulse_n_ctl = legacy_fast_reset_gate_q[`LGA_BIT_ALT_RESET_PULSE_N];
    wire alt_gate_ctl = legacy_fast_reset_gate_q[`LGA_BIT_ALT_GATE];

    // write strobe to buffer logic withheld for quiet commands and gate data [RQ9] [RQ8]
    assign kbd_wr_strobe = host_wr && (hit_cmd || hit_data) && !cmd_quiet && !data_gate;
    assign kbd_obf_irq_flag = 1'b0; // [RQ8]
    assign host_data_oe = host_rd && hit_legacy; // [RQ3]

    // ------------------------------------------------------------
    // host side
    // ------------------------------------------------------------
    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            legacy_fast_reset_gate_q <= `LGA_LEGACY_RST; // [RQ2]
            host_data_bus <= 8'h00;
        end
        else
        begin
            if (host_wr && hit_legacy)
                legacy_fast_reset_gate_q <= host_wdata; // [RQ15]
            host_data_bus <= legacy_fast_reset_gate_q;
        end
    end

    // gate sequence detector and host latch
    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= ST_IDLE;
            host_latch_q <= 1'b0;
            input_buffer_full <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (host_wr && cmd_gate)
                        state_q <= ST_ARMED;
                ST_ARMED:
                    if (host_wr && cmd_gate)
                        state_q <= ST_ARMED; // [RQ11]
                    else if (host_wr && hit_data)
                        state_q <= ST_IDLE;
                    else if (host_wr && hit_cmd && !cmd_quiet)
                        state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
            if (ec_wr && is_addr(ec_addr, `LGA_EC_A20_SET))
                host_latch_q <= 1'b1; // [RQ12]
            else if (ec_wr && is_addr(ec_addr, `LGA_EC_A20_CLR))
                host_latch_q <= 1'b0; // [RQ12]
            else if (host_wr && data_gate)
                host_latch_q <= host_wdata[`LGA_BIT_DATA_A20]; // [RQ7]
            // extra data with the detector idle reaches ibf; set beats clear [RQ10]
            if (kbd_wr_strobe)
                input_buffer_full <= 1'b1;
            else if (input_buffer_clear)
                input_buffer_full <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // ec side
    // ------------------------------------------------------------
    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            firmware_a20_control_q <= 1'b0;
            sw_a20_override_en_q <= 1'b0;
            legacy_en_q <= 1'b0;
            bar_valid_q <= 1'b0;
            sleep_en_q <= 1'b0;
            interface_activate_q <= `LGA_ACTIVATE_RST; // [RQ19]
        end
        else
        begin
            if (ec_wr)
            begin
                if (is_addr(ec_addr, `LGA_EC_A20_CTL))
                    firmware_a20_control_q <= ec_wdata[0];
                if (is_addr(ec_addr, `LGA_EC_OVR_EN))
                    sw_a20_override_en_q <= ec_wdata[0];
                if (is_addr(ec_addr, `LGA_EC_LEGACY_EN))
                    legacy_en_q <= ec_wdata[0];
                if (is_addr(ec_addr, `LGA_EC_BAR_VALID))
                    bar_valid_q <= ec_wdata[0]; // [RQ4]
                if (is_addr(ec_addr, `LGA_EC_SLEEP_EN))
                    sleep_en_q <= ec_wdata[0];
                if (is_addr(ec_addr, `LGA_EC_ACTIVATE))
                    interface_activate_q <= ec_wdata[0]; // [RQ18]
            end
            else if (cfg_wr && cfg_index == `LGA_CFG_ACTIVATE)
                interface_activate_q <= cfg_wdata[0]; // [RQ18]
        end
    end

    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ec_rdata <= 8'h00;
            cfg_rdata <= 8'h00;
        end
        else
        begin
            cfg_rdata <= (cfg_index == `LGA_CFG_ACTIVATE) ? {7'h00, interface_activate_q} : 8'h00;
            if (ec_rd)
            begin
                case (ec_addr)
                    `LGA_EC_A20_CTL: ec_rdata <= {7'h00, a20_gate_out}; // [RQ6]
                    `LGA_EC_OVR_EN: ec_rdata <= {7'h00, sw_a20_override_en_q};
                    `LGA_EC_LEGACY_EN: ec_rdata <= {7'h00, legacy_en_q};
                    `LGA_EC_BAR_VALID: ec_rdata <= {7'h00, bar_valid_q};
                    `LGA_EC_SLEEP_EN: ec_rdata <= {7'h00, sleep_en_q};
                    `LGA_EC_ACTIVATE: ec_rdata <= {7'h00, interface_activate_q};
                    default: ec_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // gate output and reset
    // ------------------------------------------------------------
    assign a20_gate_out = sw_a20_override_en_q ? firmware_a20_control_q
                          : (host_latch_q | alt_gate_ctl); // [RQ5] [RQ22]

    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gate_pin_out <= 1'b0;
            cpu_reset_out <= 1'b0;
        end
        else
        begin
            gate_pin_out <= a20_gate_out; // [RQ21]
            cpu_reset_out <= ~(alt_reset_pulse_n & kbd_reset_pulse_n); // [RQ14]
        end
    end

    lga_tick u_tick (
        .clock(clock),
        .sys_rst(sys_rst),
        .run(interface_activate_q && !sleep_en_q), // [RQ17]
        .tick(tick)
    );

    lga_pulse u_pulse (
        .clock(clock),
        .sys_rst(sys_rst),
        .ctl_bit(alt_reset_pulse_n_ctl),
        .tick(tick),
        .pulse_n(alt_reset_pulse_n)
    );
endmodule // lga_top

/* lga_top_sva.sv */
`include "lga_defs.vh"
module lga_top_sva (
    input wire clock,
    input wire sys_rst,
    input wire host_wr,
    input wire host_rd,
    input wire [15:0] host_addr,
    input wire [7:0] host_wdata,
    input wire host_data_oe,
    input wire ec_rd,
    input wire [11:0] ec_addr,
    input wire [7:0] ec_rdata,
    input wire kbd_reset_pulse_n,
    input wire kbd_wr_strobe,
    input wire input_buffer_full,
    input wire kbd_obf_irq_flag,
    input wire a20_gate_out,
    input wire gate_pin_out,
    input wire cpu_reset_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_oe_on_read: assert property (host_data_oe |-> host_rd && host_addr == `LGA_HIO_LEGACY)
        else $error("data bus driven outside legacy read");
    a_strobe_filter: assert property (kbd_wr_strobe |-> host_wr && !(host_addr == `LGA_HIO_KBD_CMD
        && host_wdata inside {`LGA_CMD_GATE, `LGA_CMD_NOP, `LGA_CMD_PULSE}))
        else $error("buffer strobe on suppressed command");
    a_obf_quiet: assert property (!kbd_obf_irq_flag)
        else $error("output buffer flag raised");
    a_ibf_on_strobe: assert property (kbd_wr_strobe |=> input_buffer_full)
        else $error("strobe did not set buffer full");
    a_kbd_merge: assert property (!kbd_reset_pulse_n |=> cpu_reset_out)
        else $error("keyboard reset not merged");
    a_ec_gate_read: assert property (ec_rd && ec_addr == `LGA_EC_A20_CTL |=> ec_rdata[0] == $past(a20_gate_out))
        else $error("gate readback differs from output");
    a_pin_copy: assert property (a20_gate_out != gate_pin_out |=> gate_pin_out == $past(a20_gate_out))
        else $error("gate pin does not follow gate");
    a_reset_clear: assert property ($fell(sys_rst) |-> !cpu_reset_out && !a20_gate_out && !input_buffer_full)
        else $error("state not cleared by reset");
    c_pulse: cover property ($rose(cpu_reset_out));
    c_oe: cover property (host_data_oe);
    c_strobe: cover property (kbd_wr_strobe);
endmodule // lga_top_sva
bind lga_top lga_top_sva u_sva (.*);

/* lga_top_tb.sv */
`include "lga_defs.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
module lga_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, sys_rst = 1, cfg_wr = 0, ec_wr = 0, ec_rd = 0, kbd_reset_pulse_n = 1, input_buffer_clear = 0, oe;
    logic [7:0] cfg_index = 8'h30, cfg_wdata = 0, ec_wdata = 0, r, d;
    logic [11:0] ec_addr = 0;
    wire host_wr, host_rd, host_data_oe, kbd_wr_strobe, input_buffer_full, kbd_obf_irq_flag;
    wire a20_gate_out, gate_pin_out, cpu_reset_out;
    wire [15:0] host_addr;
    wire [7:0] host_wdata, host_data_bus, cfg_rdata, ec_rdata;
    integer n_mismatch = 0, checks_done = 0, seed = 38, latch = 0, leg = 0, ovr = 0, fw = 0, exp_full = 0;
    integer n_strobe = 0, exp_strobe = 0;
    integer armed = 0, en = 0, i, n, hi;
    integer pw = `LGA_PULSE_US * `LGA_TICK_DIV;
    lga_top dut (.*);
    lga_host_model host (.*);
    // count buffer write strobes; the strobe is settled since the falling edge
    always @(posedge clock)
    begin
        if (kbd_wr_strobe)
            n_strobe <= n_strobe + 1;
    end
    task report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk;
        repeat (2) @(negedge clock);
        `CHK(a20_gate_out, ovr ? fw[0] : (latch[0] | leg[1]))
        `CHK(input_buffer_full, exp_full[0])
        `CHK(gate_pin_out, ovr ? fw[0] : (latch[0] | leg[1]))
        `CHK(kbd_obf_irq_flag, 1'b0)
        `CHK(n_strobe, exp_strobe)
    endtask
    task ec(input logic wr, input logic [11:0] a, input logic [7:0] v);
        @(negedge clock);
        ec_wr = wr;
        ec_rd = !wr;
        ec_addr = a;
        ec_wdata = v;
        @(negedge clock);
        r = ec_rdata;
        ec_wr = 0;
        ec_rd = 0;
        ec_wdata = ~v;
    endtask
    task io92(input logic [7:0] v);
        host.io(1, `LGA_HIO_LEGACY, v, oe, d);
        if (en)
            leg = v;
        chk;
    endtask
    task kbc(input logic cmd, input logic [7:0] v);
        host.io(1, cmd ? `LGA_HIO_KBD_CMD : `LGA_HIO_KBD_DATA, v, oe, d);
        if (!cmd && armed)
            latch = v[1];
        else if (!cmd || !(v inside {`LGA_CMD_GATE, `LGA_CMD_NOP, `LGA_CMD_PULSE}))
        begin
            exp_full = 1;
            exp_strobe++;
        end
        armed = cmd && v == `LGA_CMD_GATE;
        chk;
    endtask
    // pre: cycles of the pulse already elapsed when the measurement starts
    task pulse(input integer pre);
        n = 0;
        hi = 0;
        while (!cpu_reset_out && hi < 20)
        begin
            @(negedge clock);
            hi++;
        end
        while (cpu_reset_out && n < 5000)
        begin
            @(negedge clock);
            n++;
        end
        `CHK(n + pre >= pw - `LGA_TICK_DIV && n + pre <= pw + 4, 1'b1)
    endtask
    initial
    begin
        forever #2 clock = ~clock;
    end
    initial
    begin
        #300000;
        n_mismatch++;
        report_and_stop;
    end
    initial
    begin
        repeat (10) @(negedge clock);
        sys_rst = 0;
        ec(0, `LGA_EC_ACTIVATE, 0);
        `CHK(r[0], 1'b0)
        io92(8'h02);
        host.io(0, `LGA_HIO_LEGACY, 0, oe, d);
        `CHK(oe, 1'b0)
        ec(1, `LGA_EC_LEGACY_EN, 1);
        en = 1;
        ec(1, `LGA_EC_BAR_VALID, 8'hFF);
        ec(0, `LGA_EC_BAR_VALID, 0);
        `CHK(r, 8'h01)
        host.io(0, `LGA_HIO_LEGACY, 0, oe, d);
        `CHK({oe, d}, 9'h100)
        io92(8'h02);
        host.io(0, `LGA_HIO_LEGACY, 0, oe, d);
        `CHK(d, 8'h02)
        io92(8'h00);
        for (i = 0; i < 12; i++)
        begin
            kbc(1, `LGA_CMD_GATE);
            if (i % 3 == 0)
                kbc(1, `LGA_CMD_GATE);
            kbc(0, $random(seed));
            kbc(1, i % 2 ? `LGA_CMD_NOP : `LGA_CMD_PULSE);
        end
        kbc(1, `LGA_CMD_GATE);
        kbc(0, $random(seed));
        kbc(0, $random(seed));
        kbc(1, `LGA_CMD_GATE);
        kbc(1, 8'h20);
        @(negedge clock);
        input_buffer_clear = 1;
        @(negedge clock);
        input_buffer_clear = 0;
        exp_full = 0;
        chk;
        ec(1, `LGA_EC_OVR_EN, 1);
        ovr = 1;
        for (i = 1; i >= 0; i--)
        begin
            ec(1, `LGA_EC_A20_CTL, i);
            fw = i;
            chk;
            ec(0, `LGA_EC_A20_CTL, 0);
            `CHK(r[0], fw[0])
        end
        ec(1, `LGA_EC_OVR_EN, 0);
        ovr = 0;
        ec(1, `LGA_EC_A20_SET, $random(seed));
        latch = 1;
        chk;
        ec(0, `LGA_EC_A20_CTL, 0);
        `CHK(r[0], latch[0])
        ec(1, `LGA_EC_A20_CLR, 8'hFF);
        latch = 0;
        chk;
        ec(0, `LGA_EC_A20_CTL, 0);
        `CHK(r[0], latch[0])
        @(negedge clock);
        kbd_reset_pulse_n = 0;
        repeat (3) @(negedge clock);
        kbd_reset_pulse_n = 1;
        `CHK(cpu_reset_out, 1'b1)
        @(negedge clock);
        cfg_wr = 1;
        cfg_wdata = 1;
        @(negedge clock);
        cfg_wr = 0;
        cfg_wdata = 8'hFE;
        @(negedge clock);
        `CHK(cfg_rdata[0], 1'b1)
        @(negedge clock);
        cfg_index = 8'h31;
        cfg_wr = 1;
        cfg_wdata = 0;
        @(negedge clock);
        cfg_wr = 0;
        cfg_index = 8'h30;
        @(negedge clock);
        `CHK(cfg_rdata, 8'h01)
        io92(8'h01);
        pulse(0);
        io92(8'h00);
        io92(8'h01);
        repeat (100) @(negedge clock);
        io92(8'h00);
        io92(8'h01);
        // 100 idle cycles plus two legacy writes of four cycles each
        pulse(108);
        hi = 0;
        repeat (4000) @(negedge clock) hi += cpu_reset_out;
        `CHK(hi, 0)
        ec(1, `LGA_EC_ACTIVATE, 0);
        io92(8'h00);
        io92(8'h01);
        repeat (4000) @(negedge clock);
        `CHK(cpu_reset_out, 1'b1)
        ec(1, `LGA_EC_ACTIVATE, 1);
        ec(1, `LGA_EC_SLEEP_EN, 1);
        repeat (4000) @(negedge clock);
        `CHK(cpu_reset_out, 1'b1)
        ec(1, `LGA_EC_SLEEP_EN, 0);
        pulse(0);
        report_and_stop;
    end
endmodule // lga_top_tb
